// File: inc/pdf_consts.svh
`ifndef PDF_CONSTS_SVH
`define PDF_CONSTS_SVH
// register byte offsets
`define PDF_OFF_CTRL    8'h00
`define PDF_OFF_STATUS  8'h04
`define PDF_OFF_ERRCNT  8'h08
`define PDF_CTRL_W      5
`define PDF_CTRL_RST    5'h00
// block layout
`define PDF_HDR_DATA    2'h2
`define PDF_HDR_CTRL    2'h1
`define PDF_TYPE_CTRL   8'h1E
`define PDF_XG_IDLE     8'h07
`define PDF_XG_ERR      8'hFE
`define PDF_C_IDLE      7'h00
`define PDF_C_ERR       7'h1E
`define PDF_BLK_W       66
`define PDF_UNIT_W      16
`define PDF_FILL_BLK    7'h42
`define PDF_FILL_UNIT   7'h10
// scrambler and pattern taps
`define PDF_SCR_TAP_A   38
`define PDF_SCR_TAP_B   57
`define PDF_PRBS_TAP_A  30
`define PDF_PRBS_TAP_B  27
`define PDF_PRBS_SEED   31'h7FFFFFFF
`define PDF_SQUARE      16'h00FF
// alignment and error-rate monitor
`define PDF_LOCK_GOOD   7'h40
`define PDF_LOCK_WIN    7'h3F
`define PDF_LOCK_BAD    5'h10
`define PDF_BER_WIN     10'h3FF
`define PDF_BER_BAD     5'h10
`define PDF_ERR_MAX     16'hFFFF
`endif

// File: inc/pdf_pkg.sv
package pdf_pkg;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  ctrl;
  } pdf_xgmii_s;

  typedef enum logic [1:0] {
    PDF_PAT_SQUARE = 2'b00,
    PDF_PAT_PSEUDO = 2'b01,
    PDF_PAT_LONG   = 2'b10
  } pdf_pattern_e;

  typedef struct packed {
    pdf_pattern_e pattern;
    logic         rx_test;
    logic         tx_test;
    logic         wan_mode;
  } pdf_ctrl_s;

  typedef enum logic {
    PDF_RX_INIT = 1'b0,
    PDF_RX_RUN  = 1'b1
  } pdf_rx_state_e;

  typedef enum logic {
    PDF_SYNC_HUNT = 1'b0,
    PDF_SYNC_LOCK = 1'b1
  } pdf_sync_state_e;
endpackage

// File: verif/pdf_datapath_asserts.sv
`timescale 1ns/1ps
module pdf_datapath_asserts (
  // clock and reset
  input logic                clock,
  input logic                rst_n,
  // register bus
  input logic                psel,
  input logic                penable,
  input logic [7:0]          paddr,
  input logic                pslverr,
  // link and client
  input logic                signal_ok,
  input logic [15:0]         tx_unit,
  input pdf_pkg::pdf_xgmii_s rx_word,
  input logic                rx_valid,
  // status
  input logic                lock_flag,
  input logic                high_error_rate_flag,
  input logic                receive_health_report,
  input logic                health_changed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////////
  chk_bad_addr: assert property (
    psel && penable && paddr > 8'h08 |-> pslverr)
    else $error("missing error response");
  chk_lock_ok: assert property (
    !signal_ok [*5] |-> !lock_flag)
    else $error("lock held without signal");
  chk_lock_clean: assert property (
    $rose(lock_flag) |-> !high_error_rate_flag)
    else $error("lock rose with rate flag");
  chk_rate_gate: assert property (
    !lock_flag [*2] |-> !high_error_rate_flag)
    else $error("rate flag while unlocked");
  chk_decode_gate: assert property (
    !lock_flag [*3] |=> !rx_valid)
    else $error("decode while unlocked");
  chk_idle_fill: assert property (
    !rx_valid |-> rx_word == {32'h07070707, 4'hF})
    else $error("no idle between words");
  chk_health_fail: assert property (
    !lock_flag [*2] |-> !receive_health_report)
    else $error("health ok while unlocked");
  chk_health_note: assert property (
    $changed(receive_health_report) |-> health_changed)
    else $error("health change not signalled");
  chk_unit_pace: assert property (
    $changed(tx_unit) |=> $stable(tx_unit) [*5])
    else $error("unit changed too soon");
endmodule

bind pdf_datapath pdf_datapath_asserts u_chk (.clock, .rst_n, .psel,
  .penable, .paddr, .pslverr, .signal_ok, .tx_unit, .rx_word, .rx_valid,
  .lock_flag, .high_error_rate_flag, .receive_health_report,
  .health_changed);

// File: verif/pdf_datapath_tb.sv
`timescale 1ns/1ps
module pdf_datapath_tb;
  localparam pdf_pkg::pdf_xgmii_s IDLE = {32'h07070707, 4'hF};
  logic                clock, rst_n, psel, penable, pwrite, pready;
  logic                pslverr, tx_valid, tx_ready, rx_valid, e;
  logic                link_clock, signal_ok, ok, bad, lock_flag;
  logic                high_error_rate_flag, receive_health_report;
  logic                health_changed;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, q;
  logic [15:0]         rx_unit, tx_unit;
  pdf_pkg::pdf_xgmii_s tx_word, rx_word;
  pdf_pkg::pdf_xgmii_s txq[$];
  logic [31:0]         got[$];
  int                  err_total, tests_run, cycles;

  pdf_datapath uut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_word, .tx_valid, .tx_ready,
    .rx_word, .rx_valid, .link_clock, .rx_unit, .signal_ok, .tx_unit,
    .lock_flag, .high_error_rate_flag, .receive_health_report,
    .health_changed);
  pdf_link_model u_link (.tx_unit, .ok_in(ok), .bad, .link_clock,
    .rx_unit, .signal_ok);
////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("unexpected at %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic push(input pdf_pkg::pdf_xgmii_s w);
    tx_word <= w;
    tx_valid <= 1'b1;
    do @(posedge clock); while (tx_ready !== 1'b1);
  endtask

  // words go in pairs so a queued pair always forms one block
  initial begin
    pdf_pkg::pdf_xgmii_s a, b;
    tx_valid = 1'b0;
    tx_word = IDLE;
    wait (rst_n);
    forever begin
      a = txq.size() ? txq.pop_front() : IDLE;
      b = txq.size() ? txq.pop_front() : IDLE;
      push(a);
      push(b);
    end
  end

  always @(posedge clock)
    if (rx_valid === 1'b1 && rx_word.ctrl === 4'h0)
      got.push_back(rx_word.data);

  task automatic wait_lock;
    for (int i = 0; i < 20000 && lock_flag !== 1'b1; i++) @(posedge clock);
  endtask

  task automatic roundtrip(input logic [31:0] a, input logic [31:0] b);
    got.delete();
    txq.push_back({a, 4'h0});
    txq.push_back({b, 4'h0});
    for (int i = 0; i < 4000 && got.size() < 2; i++) @(posedge clock);
    cmp(got.size(), 32'h2);
    cmp(got[0], a);
    cmp(got[1], b);
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ok = 1'b0;
    bad = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, 8'h00, 32'h0);
    cmp(q, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    cmp(e, 32'h1);
    apb(1'b1, 8'h04, 32'hF);
    apb(1'b0, 8'h04, 32'h0);
    cmp(q, 32'h0);
    ok <= 1'b1;
    wait_lock();
    repeat (8) @(posedge clock);
    apb(1'b0, 8'h04, 32'h0);
    cmp(q, 32'hD);
    roundtrip(32'h03020100, 32'hFFEEDDCC);
    // one bad header in eight blocks: too few to unlock
    bad <= 1'b1;
    for (int i = 0; i < 20000 && high_error_rate_flag !== 1'b1; i++)
      @(posedge clock);
    repeat (4) @(posedge clock);
    cmp(high_error_rate_flag, 32'h1);
    cmp(lock_flag, 32'h1);
    cmp(receive_health_report, 32'h0);
    bad <= 1'b0;
    ok <= 1'b0;
    repeat (12) @(posedge clock);
    cmp(lock_flag, 32'h0);
    ok <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, 8'h00, 32'h6 | (p << 3));
      repeat (6000) @(posedge clock);
      apb(1'b1, 8'h08, 32'h0);
      repeat (400) @(posedge clock);
      apb(1'b0, 8'h08, 32'h0);
      if (p == 0) cmp(tx_unit, 32'h00FF);
      if (p == 1) cmp(tx_ready, 32'h0);
      if (p > 0) cmp(q, 32'h0);
      cmp(receive_health_report, 32'h0);
    end
    bad <= 1'b1;
    repeat (100) @(posedge clock);
    apb(1'b0, 8'h08, 32'h0);
    cmp(q != 32'h0, 32'h1);
    bad <= 1'b0;
    apb(1'b1, 8'h00, 32'h3);
    repeat (40) @(posedge clock);
    cmp(tx_unit == 16'h00FF, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    wait_lock();
    roundtrip(32'h80402010, 32'h01020408);
    give_verdict();
  end
endmodule

// File: verif/pdf_link_model.sv
`timescale 1ns/1ps
module pdf_link_model (
  // from the block
  input  logic [15:0] tx_unit,
  // bench controls
  input  logic        ok_in,
  input  logic        bad,
  // to the block
  output logic        link_clock,
  output logic [15:0] rx_unit,
  output logic        signal_ok
);
  // serializer clock runs free
  initial begin
    link_clock = 1'b0;
    forever #160 link_clock = ~link_clock;
  end
////////////////////////////////////////////////////////////////////////////////
  // change on the fall so the unit is settled at the rise
  always @(negedge link_clock) begin
    if (ok_in)
      rx_unit <= tx_unit ^ {15'h0000, bad};
    else
      rx_unit <= ~tx_unit;
  end
  assign signal_ok = ok_in;
endmodule

// File: verilog/pdf_datapath.sv
// Notes on behaviour
// R1: wan mode maps octet bit 0..7 to 1..8
// R2: lan unit rate set by link clock
// R3: wan unit rate slower; client stretches gaps
// R4: wan or lan attachment, software selects
// R5: four octets plus four control bits
// R6: blocks formed continuously, gearbox packs 16-bit units
// R7: wan transmit deletes idle blocks
// R8: receive units taken only while signal ok
// R9: align on two-bit header, drive lock flag
// R10: error-rate monitor after lock raises flag
// R11: decode only when locked and rate ok
// R12: wan receive inserts idles to fill rate
// R13: health report fail in init, pulse on change
// R14: rx test disables monitor, holds init, counts
// R15: tx test only without wan attachment
// R16: square and pseudo-random generate, pseudo-random check
// R17: long pattern both generated and checked
// R18: tx and rx test enables independent
// R19: words map to 66-bit blocks and back
// R20: header 01 data, 10 control
// R21: payload scrambled, header bypasses scrambler
// R22: one unit per link clock, no gaps
`timescale 1ns/1ps
`include "pdf_consts.svh"
module pdf_datapath (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // client transmit
  input  wire pdf_pkg::pdf_xgmii_s tx_word,
  input  wire logic                tx_valid,
  output logic                     tx_ready,
  // client receive
  output pdf_pkg::pdf_xgmii_s      rx_word,
  output logic                     rx_valid,
  // lower data-unit interface
  input  wire logic                link_clock,
  input  wire logic [15:0]         rx_unit,
  input  wire logic                signal_ok,
  output logic      [15:0]         tx_unit,
  // status
  output logic                     lock_flag,
  output logic                     high_error_rate_flag,
  output logic                     receive_health_report,
  output logic                     health_changed
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rev_octets(input logic [15:0] u);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[7-i]  = u[i];
      r[15-i] = u[8+i];
    end
    return r;
  endfunction

  // self-synchronous; desc selects descrambling
  function automatic logic [121:0] scramble(input logic [57:0] st_in,
                                            input logic [63:0] d,
                                            input logic        desc);
    logic [57:0] st;
    logic [63:0] q;
    logic        b;
    st = st_in;
    q = '0;
    for (int i = 0; i < 64; i++) begin
      b = d[i] ^ st[`PDF_SCR_TAP_A] ^ st[`PDF_SCR_TAP_B];
      q[i] = b;
      st = {st[56:0], desc ? d[i] : b};
    end
    return {st, q};
  endfunction

  // use_rx feeds received bits back for a self-aligning check
  function automatic logic [46:0] prbs16(input logic [30:0] st_in,
                                         input logic [15:0] rx,
                                         input logic        use_rx);
    logic [30:0] st;
    logic [15:0] q;
    logic        b;
    st = st_in;
    q = '0;
    for (int i = 0; i < 16; i++) begin
      b = st[`PDF_PRBS_TAP_A] ^ st[`PDF_PRBS_TAP_B];
      q[i] = b;
      st = {st[29:0], use_rx ? rx[i] : b};
    end
    return {st, q};
  endfunction

  function automatic logic [4:0] popcount16(input logic [15:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // data octets mixed with control become error codes (no mixed types)
  function automatic logic [65:0] encode(input pdf_pkg::pdf_xgmii_s w0,
                                         input pdf_pkg::pdf_xgmii_s w1);
    logic [63:0] d;
    logic [7:0]  c;
    logic [63:0] p;
    d = {w1.data, w0.data};
    c = {w1.ctrl, w0.ctrl};
    p = '0;
    if (c == 8'h00) begin
      return {d, `PDF_HDR_DATA}; // [R19] [R20] [R5]
    end
    p[7:0] = `PDF_TYPE_CTRL;
    for (int i = 0; i < 8; i++) begin
      p[8+7*i +: 7] = (c[i] && d[8*i +: 8] == `PDF_XG_IDLE) ?
                      `PDF_C_IDLE : `PDF_C_ERR;
    end
    return {p, `PDF_HDR_CTRL}; // [R20]
  endfunction

  function automatic logic [71:0] decode(input logic [1:0]  hdr,
                                         input logic [63:0] p);
    logic [63:0] d;
    logic [7:0]  c;
    d = p;
    c = 8'h00;
    if (hdr != `PDF_HDR_DATA) begin
      c = 8'hFF;
      for (int i = 0; i < 8; i++) begin
        d[8*i +: 8] = (hdr == `PDF_HDR_CTRL && p[7:0] == `PDF_TYPE_CTRL &&
                       p[8+7*i +: 7] == `PDF_C_IDLE) ?
                      `PDF_XG_IDLE : `PDF_XG_ERR;
      end
    end
    return {d[63:32], c[7:4], d[31:0], c[3:0]}; // [R19]
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register bus
  pdf_pkg::pdf_ctrl_s ctrl;
  logic [15:0]        err_cnt;
  logic               sok_s;
  logic               access;
  logic               mapped;
  logic               err_clr;

  assign access  = psel & penable;
  assign mapped  = (paddr == `PDF_OFF_CTRL) || (paddr == `PDF_OFF_STATUS) ||
                   (paddr == `PDF_OFF_ERRCNT);
  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign err_clr = access & pwrite & (paddr == `PDF_OFF_ERRCNT);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= pdf_pkg::pdf_ctrl_s'(`PDF_CTRL_RST);
    end else if (access && pwrite && paddr == `PDF_OFF_CTRL) begin
      ctrl <= pdf_pkg::pdf_ctrl_s'(pwdata[`PDF_CTRL_W-1:0]); // [R4] [R18]
    end
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      case (paddr)
        `PDF_OFF_CTRL:   prdata <= {27'h0, ctrl};
        `PDF_OFF_STATUS: prdata <= {28'h0, sok_s, receive_health_report,
                                    high_error_rate_flag, lock_flag};
        `PDF_OFF_ERRCNT: prdata <= {16'h0, err_cnt};
        default:         prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link pin synchronisers
  logic        lclk_m, lclk_s, lclk_d, sok_m;
  logic [15:0] rxu_m, rxu_s;
  logic        edge_rise;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lclk_m <= 1'b0;
      lclk_s <= 1'b0;
      lclk_d <= 1'b0;
      sok_m  <= 1'b0;
      sok_s  <= 1'b0;
      rxu_m  <= 16'h0;
      rxu_s  <= 16'h0;
    end else begin
      lclk_m <= link_clock;
      lclk_s <= lclk_m;
      lclk_d <= lclk_s;
      sok_m  <= signal_ok;
      sok_s  <= sok_m;
      rxu_m  <= rx_unit;
      rxu_s  <= rxu_m;
    end
  end

  // one unit each way per link clock rise, whatever its rate
  assign edge_rise = lclk_s & ~lclk_d; // [R2] [R3]

  ////////////////////////////////////////////////////////////////////////
  // transmit: assembly, idle deletion, scrambler, gearbox
  pdf_pkg::pdf_xgmii_s w0;
  logic                have_w0;
  logic [65:0]         blk;
  logic                blk_ok;
  logic [81:0]         gb;
  logic [6:0]          gb_fill;
  logic [57:0]         tx_scr;
  logic [30:0]         tx_prbs;
  logic                tx_test_on, pr_mode, tx_take, gb_hungry;
  logic                drop_idle, gb_load;
  logic [65:0]         src;
  logic [121:0]        scr;
  logic [46:0]         prbs_tx;
  logic [15:0]         next_tx_unit;

  assign tx_test_on = ctrl.tx_test & ~ctrl.wan_mode; // [R15] [R18]
  assign pr_mode    = tx_test_on & (ctrl.pattern == pdf_pkg::PDF_PAT_PSEUDO);
  assign tx_ready   = ~blk_ok & ~pr_mode;
  assign tx_take    = tx_valid & tx_ready;
  assign gb_hungry  = gb_fill <= `PDF_FILL_UNIT;
  // in wan mode, keep idles only when the gearbox would otherwise run dry
  assign drop_idle  = ctrl.wan_mode & ~gb_hungry &
                      ({w0.ctrl, tx_word.ctrl} == 8'hFF) &
                      ({w0.data, tx_word.data} == {8{`PDF_XG_IDLE}}); // [R7]
  assign gb_load    = gb_hungry & ~edge_rise & (blk_ok | pr_mode); // [R22]
  assign src        = pr_mode ? {64'h0, `PDF_HDR_DATA} : blk; // [R16]
  assign scr        = scramble(tx_scr, src[65:2], 1'b0); // [R21]
  assign prbs_tx    = prbs16(tx_prbs, 16'h0, 1'b0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w0      <= '0;
      have_w0 <= 1'b0;
      blk     <= '0;
      blk_ok  <= 1'b0;
    end else if (tx_take) begin
      if (!have_w0) begin
        w0      <= tx_word;
        have_w0 <= 1'b1;
      end else begin
        have_w0 <= 1'b0;
        if (!drop_idle) begin
          blk    <= encode(w0, tx_word); // [R6] [R19]
          blk_ok <= 1'b1;
        end
      end
    end else if (gb_load && !pr_mode) begin
      blk_ok <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gb      <= '0;
      gb_fill <= 7'h0;
      tx_scr  <= '1;
    end else if (edge_rise) begin
      if (gb_fill >= `PDF_FILL_UNIT) begin
        gb      <= gb >> `PDF_UNIT_W; // [R6]
        gb_fill <= gb_fill - `PDF_FILL_UNIT;
      end
    end else if (gb_load) begin
      gb      <= gb | ({16'h0, scr[63:0], src[1:0]} << gb_fill); // [R21]
      gb_fill <= gb_fill + `PDF_FILL_BLK;
      tx_scr  <= scr[121:64];
    end
  end

  always_comb begin
    next_tx_unit = gb[15:0];
    if (tx_test_on) begin
      case (ctrl.pattern)
        pdf_pkg::PDF_PAT_LONG:   next_tx_unit = prbs_tx[15:0]; // [R17]
        pdf_pkg::PDF_PAT_PSEUDO: next_tx_unit = gb[15:0];
        default:                 next_tx_unit = `PDF_SQUARE; // [R16]
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_unit <= 16'h0;
      tx_prbs <= `PDF_PRBS_SEED;
    end else if (edge_rise) begin
      tx_unit <= ctrl.wan_mode ? rev_octets(next_tx_unit) :
                                 next_tx_unit; // [R1]
      tx_prbs <= prbs_tx[46:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive alignment
  pdf_pkg::pdf_sync_state_e sync_state;
  logic [15:0]  rx_in;
  logic [81:0]  rb;
  logic [6:0]   rb_fill, good_cnt, win_cnt;
  logic [4:0]   bad_cnt;
  logic         hdr_ok, blk_avail, blk_taken;

  assign rx_in     = ctrl.wan_mode ? rev_octets(rxu_s) : rxu_s; // [R1]
  assign hdr_ok    = rb[0] ^ rb[1];
  assign blk_avail = (rb_fill >= `PDF_FILL_BLK) & ~edge_rise & sok_s;
  assign blk_taken = blk_avail & (sync_state == pdf_pkg::PDF_SYNC_LOCK);
  assign lock_flag = sync_state == pdf_pkg::PDF_SYNC_LOCK; // [R9]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rb         <= '0;
      rb_fill    <= 7'h0;
      sync_state <= pdf_pkg::PDF_SYNC_HUNT;
      good_cnt   <= 7'h0;
      win_cnt    <= 7'h0;
      bad_cnt    <= 5'h0;
    end else if (!sok_s) begin
      rb         <= '0; // [R8]
      rb_fill    <= 7'h0;
      sync_state <= pdf_pkg::PDF_SYNC_HUNT;
      good_cnt   <= 7'h0;
    end else if (edge_rise) begin
      rb      <= rb | ({66'h0, rx_in} << rb_fill); // [R8]
      rb_fill <= rb_fill + `PDF_FILL_UNIT;
    end else if (blk_avail) begin
      case (sync_state)
        pdf_pkg::PDF_SYNC_HUNT: begin
          win_cnt <= 7'h0;
          bad_cnt <= 5'h0;
          if (hdr_ok) begin
            rb       <= rb >> `PDF_BLK_W;
            rb_fill  <= rb_fill - `PDF_FILL_BLK;
            good_cnt <= good_cnt + 7'h1;
            if (good_cnt + 7'h1 == `PDF_LOCK_GOOD) begin
              sync_state <= pdf_pkg::PDF_SYNC_LOCK; // [R9]
            end
          end else begin
            // slip one bit and try the next boundary
            rb       <= rb >> 1;
            rb_fill  <= rb_fill - 7'h1;
            good_cnt <= 7'h0;
          end
        end
        pdf_pkg::PDF_SYNC_LOCK: begin
          rb      <= rb >> `PDF_BLK_W;
          rb_fill <= rb_fill - `PDF_FILL_BLK;
          win_cnt <= (win_cnt == `PDF_LOCK_WIN) ? 7'h0 : win_cnt + 7'h1;
          bad_cnt <= (win_cnt == `PDF_LOCK_WIN) ? 5'h0 :
                     bad_cnt + {4'h0, ~hdr_ok};
          if (!hdr_ok && bad_cnt + 5'h1 == `PDF_LOCK_BAD) begin
            sync_state <= pdf_pkg::PDF_SYNC_HUNT;
            good_cnt   <= 7'h0;
          end
        end
        default: sync_state <= pdf_pkg::PDF_SYNC_HUNT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error-rate monitor
  logic [9:0] ber_win;
  logic [4:0] ber_bad, next_ber_bad;

  assign next_ber_bad = (ber_bad == `PDF_BER_BAD) ? ber_bad :
                        ber_bad + {4'h0, ~hdr_ok};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ber_win              <= 10'h0;
      ber_bad              <= 5'h0;
      high_error_rate_flag <= 1'b0;
    end else if (!lock_flag || ctrl.rx_test) begin
      ber_win              <= 10'h0; // [R14] [R10]
      ber_bad              <= 5'h0;
      high_error_rate_flag <= 1'b0;
    end else if (blk_taken) begin
      ber_win <= ber_win + 10'h1;
      ber_bad <= (ber_win == `PDF_BER_WIN) ? 5'h0 : next_ber_bad;
      if (next_ber_bad == `PDF_BER_BAD) begin
        high_error_rate_flag <= 1'b1; // [R10]
      end else if (ber_win == `PDF_BER_WIN) begin
        high_error_rate_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive decode, idle insertion, health report
  pdf_pkg::pdf_rx_state_e rx_state, next_rx_state;
  logic [57:0]  rx_scr;
  logic [121:0] desc;
  logic [71:0]  pend;
  logic [1:0]   pend_cnt;
  logic         rx_ok, next_health;

  assign desc  = scramble(rx_scr, rb[65:2], 1'b1); // [R21]
  assign rx_ok = lock_flag & ~high_error_rate_flag & ~ctrl.rx_test; // [R11]

  always_comb begin
    case (rx_state)
      pdf_pkg::PDF_RX_INIT: next_rx_state = rx_ok ? pdf_pkg::PDF_RX_RUN :
                                                     pdf_pkg::PDF_RX_INIT;
      pdf_pkg::PDF_RX_RUN:  next_rx_state = rx_ok ? pdf_pkg::PDF_RX_RUN :
                                                     pdf_pkg::PDF_RX_INIT;
      default:              next_rx_state = pdf_pkg::PDF_RX_INIT; // [R14]
    endcase
  end

  assign next_health = next_rx_state == pdf_pkg::PDF_RX_RUN; // [R13]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_state              <= pdf_pkg::PDF_RX_INIT;
      receive_health_report <= 1'b0;
      health_changed        <= 1'b0;
    end else begin
      rx_state              <= next_rx_state;
      receive_health_report <= next_health; // [R13]
      health_changed        <= next_health != receive_health_report;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_scr   <= '1;
      pend     <= '0;
      pend_cnt <= 2'h0;
    end else begin
      if (blk_taken) begin
        rx_scr <= desc[121:64];
      end
      if (blk_taken && rx_state == pdf_pkg::PDF_RX_RUN) begin
        pend     <= decode(rb[1:0], desc[63:0]); // [R11] [R19]
        pend_cnt <= 2'h2;
      end else if (pend_cnt != 2'h0) begin
        pend_cnt <= pend_cnt - 2'h1;
      end
    end
  end

  // no block word pending: an idle fills the slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_word  <= '{data: {4{`PDF_XG_IDLE}}, ctrl: 4'hF};
      rx_valid <= 1'b0;
    end else begin
      case (pend_cnt)
        2'h2:    rx_word <= pend[35:0];
        2'h1:    rx_word <= pend[71:36];
        default: rx_word <= '{data: {4{`PDF_XG_IDLE}}, ctrl: 4'hF}; // [R12]
      endcase
      rx_valid <= pend_cnt != 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive test-pattern checker
  logic [30:0] rx_prbs;
  logic [46:0] prbs_rx;
  logic        long_chk, pr_err;
  logic [4:0]  inc;
  logic [16:0] sum;

  assign prbs_rx  = prbs16(rx_prbs, rx_in, 1'b1);
  assign long_chk = edge_rise & sok_s & ctrl.rx_test &
                    (ctrl.pattern == pdf_pkg::PDF_PAT_LONG); // [R17]
  assign pr_err   = blk_taken & ctrl.rx_test &
                    (ctrl.pattern == pdf_pkg::PDF_PAT_PSEUDO) &
                    ((rb[1:0] != `PDF_HDR_DATA) || (desc[63:0] != 64'h0));
  assign inc      = long_chk ? popcount16(prbs_rx[15:0] ^ rx_in) :
                    {4'h0, pr_err}; // [R14] [R16]
  // a clear in the same cycle as an error keeps that error
  assign sum      = {1'b0, err_clr ? 16'h0 : err_cnt} + {12'h0, inc};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_prbs <= `PDF_PRBS_SEED;
      err_cnt <= 16'h0;
    end else begin
      if (long_chk) begin
        rx_prbs <= prbs_rx[46:16];
      end
      err_cnt <= sum[16] ? `PDF_ERR_MAX : sum[15:0]; // [R14]
    end
  end

endmodule
